// ===== design/bca_defs.vh
// Register offsets, control field positions, reset values and counts of the block check accumulator.
`ifndef BCA_DEFS_VH
`define BCA_DEFS_VH

`define BCA_ADDR_W        3
`define BCA_DATA_W        16
`define BCA_OFS_CSR       3'h0
`define BCA_OFS_CHECK     3'h2
`define BCA_OFS_DATA      3'h4

`define BCA_BIT_WIDE      0
`define BCA_BIT_LONG      1
`define BCA_BIT_ALT       2
`define BCA_BIT_DOUBLE    3
`define BCA_BIT_CLEAR     4
`define BCA_BIT_STEP      5
`define BCA_BIT_SEN       6
`define BCA_BIT_DONE      7
`define BCA_BIT_QUO       8

`define BCA_RST_WORD      16'h0000
`define BCA_RST_MODE      4'h0

`define BCA_CNT_W         3
`define BCA_PRESET_FULL   3'h0
`define BCA_PRESET_SHORT  3'h2
`define BCA_CNT_LAST      3'h7

`define BCA_POLY_WIDE     16'hA001
`define BCA_POLY_CCITT    16'h8408
`define BCA_POLY_SHORT    16'h0F01

`endif

// ===== design/bca_shift_counter.v
// Shift counter that ends each character after the selected number of shifts.
`include "bca_defs.vh"
`default_nettype none

module bca_shift_counter #(
	parameter CNT_W = `BCA_CNT_W
) (
	input  wire             mclk_in,
	input  wire             sys_rst_in,
	input  wire             load_in,
	input  wire [CNT_W-1:0] preset_in,
	input  wire             double_in,
	input  wire             adv_in,
	output wire             ovf_out
);

	reg [CNT_W-1:0] cnt_reg;
	reg             half_reg;
	wire            step_cnt;

	// In word loading the count moves on every second shift only.
	assign step_cnt = adv_in & (half_reg | ~double_in);
	assign ovf_out  = step_cnt & (cnt_reg == `BCA_CNT_LAST);

	always @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			cnt_reg  <= {CNT_W{1'b0}};
			half_reg <= 1'b0;
		end
		else if (load_in)
		begin
			cnt_reg  <= preset_in;
			half_reg <= 1'b0;
		end
		else if (adv_in)
		begin
			half_reg <= double_in & ~half_reg;
			if (step_cnt)
				cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

endmodule // bca_shift_counter
`default_nettype wire

// ===== design/bca_feedback.v
// Exclusive-OR and feedback network giving the next accumulator value for one shift.
`include "bca_defs.vh"
`default_nettype none

module bca_feedback (
	input  wire [15:0] acc_in,
	input  wire        quo_in,
	input  wire        wide_in,
	input  wire        long_in,
	input  wire        alt_in,
	output reg  [15:0] acc_out
);

	always @*
	begin
		acc_out = acc_in;
		if (long_in)
		begin
			// A rotate with the data bit folded in gives the positionwise sum.
			if (wide_in)
				acc_out = {quo_in, acc_in[15:1]};
			else
				acc_out = {acc_in[15:8], quo_in, acc_in[7:1]};
		end
		else if (wide_in)
		begin
			// The quotient bit is used for feedback only and then dropped.
			acc_out = {1'b0, acc_in[15:1]} ^
				(quo_in ? (alt_in ? `BCA_POLY_CCITT : `BCA_POLY_WIDE) : 16'h0000);
		end
		else
		begin
			acc_out = {4'h0, 1'b0, acc_in[11:1]} ^ (quo_in ? `BCA_POLY_SHORT : 16'h0000);
		end
	end

endmodule // bca_feedback
`default_nettype wire

// ===== design/bca_block_check.v
// Block check accumulator: control register, data register, accumulator and shift control.
`include "bca_defs.vh"
`default_nettype none

module bca_block_check (
	input  wire                     mclk_in,
	input  wire                     sys_rst_in,
	input  wire                     bus_sel_in,
	input  wire                     bus_write_in,
	input  wire [`BCA_ADDR_W-1:0]   bus_addr_in,
	input  wire [`BCA_DATA_W-1:0]   bus_wdata_in,
	output reg  [`BCA_DATA_W-1:0]   bus_rdata_out,
	output reg                      done_out
);

	reg  [3:0]              mode_reg;
	reg                     sen_reg;
	reg                     done_reg;
	reg  [`BCA_DATA_W-1:0]  data_reg;
	reg  [`BCA_DATA_W-1:0]  acc_reg;
	reg  [`BCA_DATA_W-1:0]  rdata_next;
	reg  [3:0]              mode_next;
	reg                     sen_next;
	reg                     done_next;
	reg  [`BCA_DATA_W-1:0]  data_next;
	reg  [`BCA_DATA_W-1:0]  acc_next;

	wire                    wr_csr;
	wire                    wr_data;
	wire                    clear_hit;
	reg                     step_hit;
	reg                     run_shift;
	reg                     do_shift;
	wire                    cnt_load;
	wire                    cnt_adv;
	wire                    quo_bit;
	wire                    ovf;
	wire [`BCA_CNT_W-1:0]   preset;
	wire [`BCA_DATA_W-1:0]  acc_shifted;
	wire [`BCA_DATA_W-1:0]  data_shifted;

	genvar                  gi;

	wire wide_sel   = mode_reg[`BCA_BIT_WIDE];
	wire long_sel   = mode_reg[`BCA_BIT_LONG];
	wire alt_sel    = mode_reg[`BCA_BIT_ALT];
	wire double_sel = mode_reg[`BCA_BIT_DOUBLE];

	// Address decoding is shared by both write strobes and the read mux.
	function addr_hit;
		input [`BCA_ADDR_W-1:0] addr;
		input [`BCA_ADDR_W-1:0] ofs;
		begin
			addr_hit = (addr == ofs);
		end
	endfunction

	// Only the 12-bit cyclic code starts part way, so six shifts end a byte.
	function [`BCA_CNT_W-1:0] shift_preset;
		input long_mode;
		input wide_mode;
		begin
			if (~long_mode & ~wide_mode)
			begin
				shift_preset = `BCA_PRESET_SHORT;
			end
			else
			begin
				shift_preset = `BCA_PRESET_FULL;
			end
		end
	endfunction

	// Control word as read back; the clear and step pulses always read as zero.
	function [`BCA_DATA_W-1:0] csr_word;
		input [3:0] mode;
		input       continuous_shift_enable;
		input       done;
		input       quotient_bit;
		begin
			csr_word                = `BCA_RST_WORD;
			csr_word[3:0]           = mode;
			csr_word[`BCA_BIT_SEN]  = continuous_shift_enable;
			csr_word[`BCA_BIT_DONE] = done;
			csr_word[`BCA_BIT_QUO]  = quotient_bit;
		end
	endfunction

	// The data register moves one place toward bit 0 per shift, LSB first.
	generate
		for (gi = 0; gi < `BCA_DATA_W; gi = gi + 1)
		begin : g_data_shift
			if (gi == `BCA_DATA_W - 1)
			begin : g_top
				assign data_shifted[gi] = 1'b0;
			end
			else
			begin : g_low
				assign data_shifted[gi] = data_reg[gi + 1];
			end
		end
	endgenerate

	assign wr_csr  = bus_sel_in & bus_write_in & addr_hit(bus_addr_in, `BCA_OFS_CSR);
	assign wr_data = bus_sel_in & bus_write_in & addr_hit(bus_addr_in, `BCA_OFS_DATA);

	assign clear_hit = wr_csr & bus_wdata_in[`BCA_BIT_CLEAR];
	// Holding off while the data write is still on the bus keeps the word stable.
	always @*
	begin
		step_hit  = 1'b0;
		run_shift = 1'b0;
		if (wr_csr & bus_wdata_in[`BCA_BIT_STEP])
		begin
			// A step written together with shift enable is ignored.
			step_hit = ~bus_wdata_in[`BCA_BIT_SEN] & ~sen_reg;
		end
		if (~done_reg & sen_reg & ~wr_data)
		begin
			run_shift = 1'b1;
		end
		do_shift = ~clear_hit & (run_shift | step_hit);
	end

	assign quo_bit = data_reg[0] ^ acc_reg[0];

	assign preset = shift_preset(long_sel, wide_sel);

	// A step taken while idle must not move the counter, or the next character comes up short.
	assign cnt_load = wr_data | clear_hit;
	assign cnt_adv  = do_shift & ~done_reg;

	bca_shift_counter #(
		.CNT_W     (`BCA_CNT_W)
	) u_counter (
		.mclk_in   (mclk_in),
		.sys_rst_in(sys_rst_in),
		.load_in   (cnt_load),
		.preset_in (preset),
		.double_in (double_sel),
		.adv_in    (cnt_adv),
		.ovf_out   (ovf)
	);

	bca_feedback u_feedback (
		.acc_in (acc_reg),
		.quo_in (quo_bit),
		.wide_in(wide_sel),
		.long_in(long_sel),
		.alt_in (alt_sel),
		.acc_out(acc_shifted)
	);

	// Control register next values.
	always @*
	begin
		mode_next = mode_reg;
		sen_next  = sen_reg;
		if (wr_csr)
		begin
			mode_next = bus_wdata_in[3:0];
			sen_next  = bus_wdata_in[`BCA_BIT_SEN];
		end
	end

	// Clear and data write use different offsets; a new character beats a late overflow.
	always @*
	begin
		done_next = done_reg;
		if (clear_hit)
		begin
			done_next = 1'b1;
		end
		else if (wr_data)
		begin
			done_next = 1'b0;
		end
		else if (ovf)
		begin
			done_next = 1'b1;
		end
	end

	// Byte loading keeps only the low byte, the earlier character.
	always @*
	begin
		data_next = data_reg;
		if (wr_data)
		begin
			if (double_sel)
			begin
				data_next = bus_wdata_in;
			end
			else
			begin
				data_next = {8'h00, bus_wdata_in[7:0]};
			end
		end
		else if (do_shift)
		begin
			data_next = data_shifted;
		end
	end

	// The accumulator is never loaded from the bus, only cleared or shifted.
	always @*
	begin
		acc_next = acc_reg;
		if (clear_hit)
		begin
			acc_next = `BCA_RST_WORD;
		end
		else if (do_shift)
		begin
			acc_next = acc_shifted;
		end
	end

	// Control register and done flag.
	always @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			mode_reg <= `BCA_RST_MODE;
			sen_reg  <= 1'b0;
			done_reg <= 1'b1;
		end
		else
		begin
			mode_reg <= mode_next;
			sen_reg  <= sen_next;
			done_reg <= done_next;
		end
	end

	// Data and accumulator registers.
	always @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			data_reg <= `BCA_RST_WORD;
			acc_reg  <= `BCA_RST_WORD;
		end
		else
		begin
			data_reg <= data_next;
			acc_reg  <= acc_next;
		end
	end

	// Read data is registered, so it appears one edge after the address.
	always @*
	begin
		rdata_next = `BCA_RST_WORD;
		if (bus_sel_in & ~bus_write_in)
		begin
			if (addr_hit(bus_addr_in, `BCA_OFS_CSR))
			begin
				rdata_next = csr_word(mode_reg, sen_reg, done_reg, quo_bit);
			end
			else if (addr_hit(bus_addr_in, `BCA_OFS_CHECK))
			begin
				rdata_next = acc_reg;
			end
			else if (addr_hit(bus_addr_in, `BCA_OFS_DATA))
			begin
				rdata_next = data_reg;
			end
			else
			begin
				rdata_next = `BCA_RST_WORD;
			end
		end
	end

	always @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			bus_rdata_out <= `BCA_RST_WORD;
		end
		else
		begin
			bus_rdata_out <= rdata_next;
		end
	end

	// The done copy lags the flag by one edge; the registered control register read shows it at the same edge.
	always @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			done_out <= 1'b1;
		end
		else
		begin
			done_out <= done_reg;
		end
	end

endmodule // bca_block_check
`default_nettype wire

// ===== tb/bca_asserts.sv
// Port assertions for the block check accumulator.
`default_nettype none
module bca_asserts (
	input wire logic        mclk_in,
	input wire logic        sys_rst_in,
	input wire logic        bus_sel_in,
	input wire logic        bus_write_in,
	input wire logic [2:0]  bus_addr_in,
	input wire logic [15:0] bus_wdata_in,
	input wire logic [15:0] bus_rdata_out,
	input wire logic        done_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	wire logic rd = bus_sel_in && !bus_write_in;
	wire logic wr = bus_sel_in && bus_write_in;
	sequence clr_wr; wr && bus_addr_in == 3'h0 && bus_wdata_in[4]; endsequence
	sequence dat_wr; wr && bus_addr_in == 3'h4; endsequence
	AST_RD_IDLE: assert property (!rd |=> bus_rdata_out == 16'h0000)
		else $error("rdata not zero");
	AST_RD_UNMAP: assert property (rd && bus_addr_in == 3'h6 |=> bus_rdata_out == 16'h0000)
		else $error("unmapped read not zero");
	AST_RD_RSVD: assert property (rd && bus_addr_in == 3'h0 |=> bus_rdata_out[15:9] == 7'h00)
		else $error("spare bits set");
	AST_DATA_DONE: assert property (dat_wr |-> ##2 !done_out)
		else $error("done kept");
	// Six shifts is the shortest character, so done stays low at least five cycles.
	AST_SHIFT_MIN: assert property (dat_wr ##1 !bus_sel_in |-> ##1 !done_out [*5])
		else $error("done early");
	AST_CLR_DONE: assert property (clr_wr |-> ##2 done_out)
		else $error("done not set");
	AST_CLR_ZERO: assert property (clr_wr ##2 rd && bus_addr_in == 3'h2
		|=> bus_rdata_out == 16'h0000) else $error("not cleared");
	AST_CSR_MODE: assert property (wr && bus_addr_in == 3'h0 ##2 rd && bus_addr_in == 3'h0
		|=> bus_rdata_out[3:0] == $past(bus_wdata_in[3:0], 3)) else $error("mode lost");
endmodule // bca_asserts
bind bca_block_check bca_asserts u_chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
	.bus_sel_in(bus_sel_in), .bus_write_in(bus_write_in), .bus_addr_in(bus_addr_in),
	.bus_wdata_in(bus_wdata_in), .bus_rdata_out(bus_rdata_out), .done_out(done_out));
`default_nettype wire

// ===== tb/bca_host.sv
// Host model issuing register cycles to the block check accumulator.
`default_nettype none
module bca_host (
	input  wire logic        clk_in,
	input  wire logic [15:0] rdata_in,
	output var  logic        sel_out = 1'b0,
	output var  logic        write_out = 1'b0,
	output var  logic [2:0]  addr_out = 3'h0,
	output var  logic [15:0] wdata_out = 16'h0000
);
	timeunit 1ns;
	timeprecision 1ns;
	// Each cycle is taken at one edge and released at the next, so calls never overlap.
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_in);
		sel_out <= 1'b1;
		write_out <= 1'b1;
		addr_out <= a;
		wdata_out <= d;
		@(posedge clk_in);
		sel_out <= 1'b0;
		wdata_out <= ~d;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk_in);
		sel_out <= 1'b1;
		write_out <= 1'b0;
		addr_out <= a;
		@(posedge clk_in);
		sel_out <= 1'b0;
		#1;
		d = rdata_in;
	endtask
endmodule // bca_host
`default_nettype wire

// ===== tb/tb_block_check_accumulator.sv
// Self-checking bench for the block check accumulator.
`include "bca_defs.vh"
`default_nettype none
module tb_block_check_accumulator;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        sel;
	logic        we;
	logic [2:0]  addr;
	logic [15:0] wdat;
	logic [15:0] rdat;
	logic        done;
	logic [15:0] got;
	logic [15:0] acc;
	logic [3:0]  modes [7] = '{4'h1, 4'h5, 4'h0, 4'h2, 4'hB, 4'h9, 4'h8};
	int          fail_count = 0;
	int          num_checks = 0;
	always #25 clk = ~clk;
	bca_block_check dut (.mclk_in(clk), .sys_rst_in(rst), .bus_sel_in(sel),
		.bus_write_in(we), .bus_addr_in(addr), .bus_wdata_in(wdat),
		.bus_rdata_out(rdat), .done_out(done));
	bca_host host (.clk_in(clk), .rdata_in(rdat), .sel_out(sel), .write_out(we),
		.addr_out(addr), .wdata_out(wdat));
	task automatic summarize;
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wait_done;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 40 && done !== 1'b1; i++)
			@(posedge clk);
		check({15'h0000, done}, 16'h0001);
		if (done !== 1'b1)
			summarize();
	endtask
	// Serial model, LSB first; parity sums fold the whole character at once.
	function automatic logic [15:0] fold(logic [15:0] a, logic [15:0] d, logic [3:0] m);
		int n;
		logic [15:0] p;
		if (m[1])
			return a ^ (m[3] ? d : {8'h00, d[7:0]});
		p = m[0] ? (m[2] ? `BCA_POLY_CCITT : `BCA_POLY_WIDE) : `BCA_POLY_SHORT;
		n = (m[3] ? 16 : 8) - (m[0] ? 0 : (m[3] ? 4 : 2));
		for (int i = 0; i < n; i++)
			a = (a >> 1) ^ ((a[0] ^ d[i]) ? p : 16'h0000);
		return a;
	endfunction
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		host.rd(3'h0, got);
		check(got, 16'h0080);
		host.rd(3'h6, got);
		check(got, 16'h0000);
		foreach (modes[k])
		begin
			host.wr(3'h0, 16'h0050 | modes[k]);
			host.rd(3'h0, got);
			check(got & 16'hFEFF, 16'h00C0 | modes[k]);
			acc = 16'h0000;
			for (int j = 0; j < 2; j++)
			begin
				host.wr(3'h4, j ? 16'h6E29 : 16'hA5C3);
				wait_done();
				acc = fold(acc, j ? 16'h6E29 : 16'hA5C3, modes[k]);
				host.rd(3'h2, got);
				check(got, acc);
			end
		end
		host.wr(3'h0, 16'h0011);
		host.rd(3'h2, got);
		check(got, 16'h0000);
		host.wr(3'h4, 16'h0001);
		host.rd(3'h0, got);
		check(got, 16'h0101);
		host.wr(3'h0, 16'h0021);
		host.rd(3'h2, got);
		check(got, `BCA_POLY_WIDE);
		summarize();
	end
endmodule // tb_block_check_accumulator
`default_nettype wire
